//--- design/rrx_exec.sv
/*
 * rrx_exec: executes software reset, the three stack returns, rotate-left through
 * carry and call pushes, and exposes its state over an APB slave.
 * Assumes the decoder issues only while busy is low and supplies the file operand
 * with the issue; all inputs are on core_clk.
 */
// Functional notes
// - reset instruction pulses device reset, clears flag
// - interrupt return pops stack, loads pc, two cycles
// - interrupt return sets global enable bit seven
// - plain return pops into pc, two cycles
// - literal return loads accumulator and pc, two cycles
// - literal 0 to 255, flags untouched
// - rotate left through carry, bit7 to carry
// - destination bit selects accumulator or file
// - rotate addresses 0-127, one cycle, carry only
`timescale 1ns/1ps
module rrx_exec (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire rrx_pkg::rrx_issue_type issue,
    output rrx_pkg::rrx_fwrite_type fwrite,
    output logic [rrx_pkg::PC_W-1:0] pc_q_out,
    output logic pc_load,
    output logic [7:0] acc,
    output logic carry,
    output logic global_interrupt_enable,
    output logic reset_instruction_flag,
    output logic soft_reset,
    output logic busy,
    output logic done,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import rrx_pkg::*;

    typedef struct packed {
        rrx_state_type st;
        logic busy;
        logic ret_int_en;
        logic en;
        logic [SP_W-1:0] sp;
        logic [PC_W-1:0] pc;
        logic pc_load;
        logic [7:0] acc;
        logic carry;
        logic int_en;
        logic rst_flag;
        logic soft_reset;
        logic done;
        rrx_fwrite_type fw;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } rrx_regs_type;

    rrx_regs_type r_q;
    rrx_regs_type r_d;

    logic mem_we;
    logic mem_re;
    logic [SP_W-1:0] mem_raddr;
    logic [PC_W-1:0] mem_rdata;
    logic take;
    logic apb_wr;
    logic mapped;
    logic [31:0] rd_val;
    logic [8:0] rot;

    assign take = issue.valid && r_q.en && (r_q.st == ST_IDLE);
    assign mem_we = take && (issue.op == OP_PUSH);
    assign mem_re = take && (issue.op inside {OP_RETURN, OP_RETINT, OP_RETLIT});
    // pop reads the entry just below the pointer
    assign mem_raddr = r_q.sp - 4'h1;
    // old carry into bit 0, old bit 7 out as new carry
    assign rot = {issue.file_rdata, r_q.carry};

    rrx_stack_mem u_stack (
        .core_clk(core_clk),
        .ce(ce),
        .we(mem_we),
        .waddr(r_q.sp),
        .wdata(issue.push_pc),
        .re(mem_re),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr)
            CTRL_OFS: rd_val[CTRL_EN_BIT] = r_q.en;
            ACC_OFS: rd_val[7:0] = r_q.acc;
            STATUS_OFS: rd_val[CARRY_BIT] = r_q.carry;
            INTCTL_OFS: rd_val[INT_EN_BIT] = r_q.int_en;
            PWRSTAT_OFS: rd_val[RST_FLAG_BIT] = r_q.rst_flag;
            PC_OFS: rd_val[PC_W-1:0] = r_q.pc;
            SP_OFS: rd_val[SP_W-1:0] = r_q.sp;
            default: mapped = 1'b0;
        endcase
    end

    assign apb_wr = psel && penable && r_q.pready && pwrite && mapped;

    always_comb begin
        r_d = r_q;
        r_d.soft_reset = 1'b0;
        r_d.done = 1'b0;
        r_d.pc_load = 1'b0;
        r_d.fw.we = 1'b0;
        // apb: answer one cycle into the access phase
        r_d.pready = psel && penable && !r_q.pready;
        if (psel && penable && !r_q.pready) begin
            r_d.prdata = pwrite ? 32'h0000_0000 : rd_val;
            r_d.pslverr = !mapped;
        end else begin
            r_d.pslverr = 1'b0;
        end
        if (apb_wr) begin
            case (paddr)
                CTRL_OFS: r_d.en = pwdata[CTRL_EN_BIT];
                ACC_OFS: r_d.acc = pwdata[7:0];
                STATUS_OFS: r_d.carry = pwdata[CARRY_BIT];
                INTCTL_OFS: r_d.int_en = pwdata[INT_EN_BIT];
                PWRSTAT_OFS: r_d.rst_flag = pwdata[RST_FLAG_BIT];
                default: r_d.en = r_q.en;
            endcase
        end
        // instruction effects come after software writes so hardware wins
        case (r_q.st)
            ST_IDLE: begin
                if (take) begin
                    case (issue.op)
                        OP_SOFT_RESET: begin
                            // device reset request, flag cleared, no arithmetic flags
                            r_d.soft_reset = 1'b1;
                            r_d.rst_flag = 1'b0;
                            r_d.done = 1'b1;
                        end
                        OP_RETURN, OP_RETINT: begin
                            r_d.st = ST_POP;
                            r_d.ret_int_en = (issue.op == OP_RETINT);
                            r_d.sp = r_q.sp - 4'h1;
                        end
                        OP_RETLIT: begin
                            // any 8-bit literal accepted; carry untouched
                            r_d.acc = issue.literal;
                            r_d.st = ST_POP;
                            r_d.ret_int_en = 1'b0;
                            r_d.sp = r_q.sp - 4'h1;
                        end
                        OP_ROTL: begin
                            r_d.carry = rot[8];
                            r_d.done = 1'b1;
                            if (issue.dest_file) begin
                                r_d.fw.we = 1'b1;
                                r_d.fw.addr = issue.faddr;
                                r_d.fw.data = rot[7:0];
                            end else begin
                                r_d.acc = rot[7:0];
                            end
                        end
                        OP_PUSH: begin
                            r_d.sp = r_q.sp + 4'h1;
                            r_d.done = 1'b1;
                        end
                        default: r_d.done = 1'b0;
                    endcase
                end
            end
            ST_POP: begin
                // second cycle: popped entry lands in pc
                r_d.pc = mem_rdata;
                r_d.pc_load = 1'b1;
                r_d.done = 1'b1;
                r_d.st = ST_IDLE;
                if (r_q.ret_int_en) begin
                    r_d.int_en = 1'b1;
                end
            end
            default: r_d.st = ST_IDLE;
        endcase
        // registered so that busy leaves a flip-flop directly
        r_d.busy = (r_d.st == ST_POP);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            r_q <= '0;
            r_q.st <= ST_IDLE;
            r_q.en <= CTRL_EN_RST;
            r_q.rst_flag <= RST_FLAG_RST;
            r_q.acc <= ACC_RST;
            r_q.pc <= PC_RST;
        end else if (ce) begin
            r_q <= r_d;
        end
    end

    assign fwrite = r_q.fw;
    assign pc_q_out = r_q.pc;
    assign pc_load = r_q.pc_load;
    assign acc = r_q.acc;
    assign carry = r_q.carry;
    assign global_interrupt_enable = r_q.int_en;
    assign reset_instruction_flag = r_q.rst_flag;
    assign soft_reset = r_q.soft_reset;
    assign busy = r_q.busy;
    assign done = r_q.done;
    assign prdata = r_q.prdata;
    assign pready = r_q.pready;
    assign pslverr = r_q.pslverr;
endmodule

//--- common/rrx_pkg.sv
/*
 * rrx_pkg: shared constants and types for the return/reset/rotate execution block.
 * Assumes a 32-bit APB register bus and a core that issues one decoded instruction at a time.
 */
package rrx_pkg;
    localparam int PC_W = 15;
    localparam int SP_W = 4;
    localparam int STACK_DEPTH = 16;
    localparam int FADDR_W = 7;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] ACC_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] INTCTL_OFS = 8'h0c;
    localparam logic [7:0] PWRSTAT_OFS = 8'h10;
    localparam logic [7:0] PC_OFS = 8'h14;
    localparam logic [7:0] SP_OFS = 8'h18;
    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CARRY_BIT = 0;
    localparam int INT_EN_BIT = 7;
    localparam int RST_FLAG_BIT = 2;
    // reset values
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic RST_FLAG_RST = 1'b1;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 15'h0000;
    // cycles from issue to completion of a stack return
    localparam int RET_CYCLES = 2;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_SOFT_RESET = 3'h1,
        OP_RETURN = 3'h2,
        OP_RETINT = 3'h3,
        OP_RETLIT = 3'h4,
        OP_ROTL = 3'h5,
        OP_PUSH = 3'h6
    } rrx_op_type;

    typedef struct packed {
        logic valid;
        rrx_op_type op;
        logic [FADDR_W-1:0] faddr;
        logic dest_file;
        logic [7:0] literal;
        logic [7:0] file_rdata;
        logic [PC_W-1:0] push_pc;
    } rrx_issue_type;

    typedef struct packed {
        logic we;
        logic [FADDR_W-1:0] addr;
        logic [7:0] data;
    } rrx_fwrite_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_POP = 2'b10
    } rrx_state_type;
endpackage

//--- design/rrx_stack_mem.sv
/*
 * rrx_stack_mem: return-address store, one write port and one read port.
 * Read data come out of a register one cycle after the read enable; ce freezes it.
 */
`timescale 1ns/1ps
module rrx_stack_mem (
    input wire logic core_clk,
    input wire logic ce,
    input wire logic we,
    input wire logic [rrx_pkg::SP_W-1:0] waddr,
    input wire logic [rrx_pkg::PC_W-1:0] wdata,
    input wire logic re,
    input wire logic [rrx_pkg::SP_W-1:0] raddr,
    output logic [rrx_pkg::PC_W-1:0] rdata
);
    import rrx_pkg::*;

    logic [PC_W-1:0] mem [STACK_DEPTH];

    always_ff @(posedge core_clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
        if (ce && re) begin
            rdata <= mem[raddr];
        end
    end
endmodule

//--- verif/rrx_exec_properties.sv
/*
 * rrx_exec_properties: concurrent checks on the rrx_exec ports, bound below.
 * Assumes one core_clk domain, ce held high and rstn active low.
 */
`timescale 1ns/1ps
module rrx_exec_properties (
    input wire logic core_clk,
    input wire logic rstn,
    input wire rrx_pkg::rrx_issue_type issue,
    input wire rrx_pkg::rrx_fwrite_type fwrite,
    input wire logic [7:0] acc,
    input wire logic carry,
    input wire logic global_interrupt_enable,
    input wire logic reset_instruction_flag,
    input wire logic soft_reset,
    input wire logic busy,
    input wire logic done,
    input wire logic pc_load
);
    import rrx_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_pop_end;
        ##1 pc_load && done && !busy;
    endsequence
    sequence s_rot_issue;
        $past(issue.valid) && $past(issue.op) == OP_ROTL && done && !pc_load;
    endsequence
    a_reset_clears_flag: assert property (soft_reset |-> !reset_instruction_flag && done)
        else $error("soft reset without flag clear");
    a_pop_two_cycles: assert property (busy |-> s_pop_end)
        else $error("return did not end in its second cycle");
    a_load_after_busy: assert property (pc_load |-> $past(busy) && done)
        else $error("pc load without busy cycle");
    a_retint_sets_enable: assert property (pc_load && $past(issue.valid, 2)
        && $past(issue.op, 2) == OP_RETINT |-> global_interrupt_enable)
        else $error("interrupt return left enable low");
    a_retlit_loads_acc: assert property (pc_load && $past(issue.valid, 2)
        && $past(issue.op, 2) == OP_RETLIT |-> acc == $past(issue.literal, 2))
        else $error("literal return acc wrong");
    a_rotate_carry_out: assert property (s_rot_issue |-> carry == $past(issue.file_rdata[7]))
        else $error("rotate carry wrong");
    a_rotate_to_file: assert property (fwrite.we |-> fwrite.addr == $past(issue.faddr)
        && fwrite.data == {$past(issue.file_rdata[6:0]), $past(carry)})
        else $error("rotate file write wrong");
    a_rotate_to_acc: assert property (s_rot_issue ##0 !$past(issue.dest_file) |-> !fwrite.we
        && acc == {$past(issue.file_rdata[6:0]), $past(carry)})
        else $error("rotate acc result wrong");
endmodule
bind rrx_exec rrx_exec_properties u_props (.core_clk(core_clk), .rstn(rstn), .issue(issue),
    .fwrite(fwrite), .acc(acc), .carry(carry), .global_interrupt_enable(global_interrupt_enable),
    .reset_instruction_flag(reset_instruction_flag), .soft_reset(soft_reset), .busy(busy),
    .done(done), .pc_load(pc_load));

//--- verif/tb_top.sv
/*
 * tb_top: self-checking bench for rrx_exec, instructions on the issue port, state over APB.
 * Assumes ce held high and a 100 MHz core_clk.
 */
`timescale 1ns/1ps
module tb_top;
    import rrx_pkg::*;
    logic core_clk, rstn, ce, psel, penable, pwrite, pready, pslverr, pc_load, carry, er, sr;
    logic busy, done, soft_reset, global_interrupt_enable, reset_instruction_flag;
    logic [7:0] paddr, acc;
    logic [31:0] pwdata, prdata, rd;
    logic [PC_W-1:0] pc_q_out;
    rrx_issue_type issue;
    rrx_fwrite_type fwrite, fw;
    int bad_count, comparisons, lat;
    rrx_exec DUT (.core_clk(core_clk), .rstn(rstn), .ce(ce), .issue(issue), .fwrite(fwrite),
        .pc_q_out(pc_q_out), .pc_load(pc_load), .acc(acc), .carry(carry),
        .global_interrupt_enable(global_interrupt_enable),
        .reset_instruction_flag(reset_instruction_flag), .soft_reset(soft_reset),
        .busy(busy), .done(done), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        // answer and read data are taken at the edge that samples pready high
        for (int n = 0; n < 20; n++) begin
            @(posedge core_clk);
            if (pready === 1'b1) begin
                rd = prdata;
                er = pslverr;
                psel <= 1'b0;
                penable <= 1'b0;
                return;
            end
        end
        bad_count++;
        wrap_up();
    endtask
    // file operand always at the top address 127
    task automatic iss(input rrx_op_type op, input logic [7:0] lit, input logic [7:0] frd,
        input logic dst, input logic [PC_W-1:0] ppc);
        @(posedge core_clk);
        issue <= '{1'b1, op, 7'h7f, dst, lit, frd, ppc};
        @(posedge core_clk);
        issue.valid <= 1'b0;
        for (lat = 1; lat < 8; lat++) begin
            @(posedge core_clk);
            if (done === 1'b1) begin
                fw = fwrite;
                sr = soft_reset;
                return;
            end
        end
        bad_count++;
        wrap_up();
    endtask
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        issue = '0;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        chk("acc", acc, 32'h0);
        chk("reset flag", reset_instruction_flag, 32'h1);
        for (int i = 0; i < 3; i++) iss(OP_PUSH, 8'h00, 8'h00, 1'b0, 15'h0100 + 15'(i));
        apb(1'b1, INTCTL_OFS, 32'h0);
        iss(OP_RETINT, 8'h00, 8'h00, 1'b0, 15'h0);
        chk("int return cycles", lat, RET_CYCLES);
        chk("pc", pc_q_out, 32'h102);
        chk("int enable", global_interrupt_enable, 32'h1);
        apb(1'b0, INTCTL_OFS, 32'h0);
        chk("intctl", rd, 32'h80);
        chk("read err", er, 32'h0);
        // carry set beforehand so that a stray flag change shows
        apb(1'b1, STATUS_OFS, 32'h1);
        iss(OP_RETURN, 8'h00, 8'h00, 1'b0, 15'h0);
        chk("return cycles", lat, RET_CYCLES);
        chk("pc", pc_q_out, 32'h101);
        chk("carry", carry, 32'h1);
        iss(OP_RETLIT, 8'hff, 8'h00, 1'b0, 15'h0);
        chk("retlit cycles", lat, RET_CYCLES);
        chk("acc", acc, 32'hff);
        chk("pc", pc_q_out, 32'h100);
        chk("carry", carry, 32'h1);
        apb(1'b0, SP_OFS, 32'h0);
        chk("sp", rd, 32'h0);
        apb(1'b1, STATUS_OFS, 32'h0);
        iss(OP_ROTL, 8'h00, 8'he6, 1'b0, 15'h0);
        chk("rotate cycles", lat, 32'h1);
        chk("acc", acc, 32'hcc);
        chk("carry", carry, 32'h1);
        chk("file we", fw.we, 32'h0);
        iss(OP_ROTL, 8'h00, 8'h01, 1'b1, 15'h0);
        chk("fwrite", fw, {1'b1, 7'h7f, 8'h03});
        chk("acc", acc, 32'hcc);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("status", rd, 32'h0);
        apb(1'b1, STATUS_OFS, 32'h1);
        iss(OP_SOFT_RESET, 8'h00, 8'h00, 1'b0, 15'h0);
        chk("soft reset", sr, 32'h1);
        chk("carry", carry, 32'h1);
        apb(1'b0, PWRSTAT_OFS, 32'h0);
        chk("pwrstat", rd, 32'h0);
        // issues are dropped while execution is disabled
        apb(1'b1, CTRL_OFS, 32'h0);
        @(posedge core_clk);
        issue <= '{1'b1, OP_PUSH, 7'h7f, 1'b0, 8'h00, 8'h00, 15'h0};
        @(posedge core_clk);
        issue.valid <= 1'b0;
        @(posedge core_clk);
        chk("done disabled", done, 32'h0);
        apb(1'b0, SP_OFS, 32'h0);
        chk("sp disabled", rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped err", er, 32'h1);
        chk("unmapped data", rd, 32'h0);
        wrap_up();
    end
endmodule
